// file: pcmsig_exp_if.sv
// -------------------------------------------------------------------
// companded byte in, linear sample out
// -------------------------------------------------------------------
interface pcmsig_exp_if;
  logic        [7:0]  code;
  logic               ulaw;
  logic               half_lsb;
  logic signed [15:0] linear;
  modport expander (input code, input ulaw, input half_lsb, output linear);
  modport user     (output code, output ulaw, output half_lsb, input linear);
endinterface : pcmsig_exp_if

// file: pcmsig_expander.sv
// -------------------------------------------------------------------
// g.711 expander with half-lsb substitution
// -------------------------------------------------------------------
module pcmsig_expander (
  pcmsig_exp_if.expander x
);

  // decode; half_lsb drops the mantissa lsb and adds half its weight
  always_comb begin
    logic [7:0]  u;
    logic [2:0]  seg;
    logic [3:0]  mant;
    logic [15:0] t;
    u    = x.ulaw ? ~x.code : (x.code ^ 8'h55);
    seg  = u[6:4];
    mant = u[3:0];
    t    = 16'h0000;
    if (x.ulaw) begin
      t = {9'h000, mant[3:1], (x.half_lsb ? 1'b0 : mant[0]), x.half_lsb, 2'h0};
      t = (t + 16'h0084) << seg;
      t = t - 16'h0084;
      x.linear = u[7] ? -$signed(t) : $signed(t);
    end else begin
      // a-law never substitutes: robbed bits exist only under mu-law
      t = {8'h00, mant, 4'h0};
      if (seg == 3'h0) begin
        t = t + 16'h0008;
      end else begin
        t = (t + 16'h0108) << (seg - 3'h1);
      end
      x.linear = u[7] ? $signed(t) : -$signed(t);
    end
  end

endmodule : pcmsig_expander

// file: pcmsig_framer.sv
module pcmsig_framer #(
  parameter int HOOK_DEBOUNCE_CYCLES = pcmsig_pkg::HOOK_DEBOUNCE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  input  wire logic        pcm_clk,
  input  wire logic        frame_sync,
  input  wire logic        pcm_rx_data,
  output logic             pcm_tx_out,
  output logic             pcm_tx_oe,
  input  wire logic        hook_detect_input,
  input  wire logic        second_line_input,
  input  wire logic        muxed_hook_input,
  input  wire logic        clock_fail_flag
);

  localparam int DB_W = $clog2(HOOK_DEBOUNCE_CYCLES + 1);
  localparam int BW   = pcmsig_pkg::BIT_CNT_W;

  if (HOOK_DEBOUNCE_CYCLES < 1) begin : g_bad_debounce
    $error("debounce count must be at least one cycle");
  end

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  logic [pcmsig_pkg::SYNC_N-1:0] pins_raw;
  logic [pcmsig_pkg::SYNC_N-1:0] sync_a;
  logic [pcmsig_pkg::SYNC_N-1:0] sync_b;
  assign pins_raw = {clock_fail_flag, muxed_hook_input, second_line_input,
                     hook_detect_input, pcm_rx_data, frame_sync, pcm_clk};

  for (genvar i = 0; i < pcmsig_pkg::SYNC_N; i++) begin : g_sync
    // two flops; only the second one is ever read
    always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
      end else begin
        sync_a[i] <= pins_raw[i];
        sync_b[i] <= sync_a[i];
      end
    end
  end

  logic pclk_s, fs_s, rxd_s, hook_s, line2_s, mux_s, clock_fail_flag_s;
  assign {clock_fail_flag_s, mux_s, line2_s, hook_s, rxd_s, fs_s, pclk_s} = sync_b;

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  logic [pcmsig_pkg::CTRL_W-1:0]  ctrl;
  logic [pcmsig_pkg::SLOT_W-1:0]  tx_slot;
  logic [pcmsig_pkg::SLOT_W-1:0]  rx_slot;
  logic [pcmsig_pkg::CSLOT_W-1:0] clock_slot;
  logic [15:0]                    tx_data;
  logic [15:0]                    rx_data;
  logic [15:0]                    rx_linear;
  logic [pcmsig_pkg::IRQ_W-1:0]   irq_status;
  logic [pcmsig_pkg::IRQ_W-1:0]   irq_mask;
  logic [pcmsig_pkg::IRQ_W-1:0]   irq_set;
  logic                           bus_done;
  logic                           sel_ctrl, sel_slot, sel_tx;

  wire signaling_slot_enable = ctrl[pcmsig_pkg::CTRL_SIG_EN_BIT];
  wire robbed_bit_enable     = ctrl[pcmsig_pkg::CTRL_RBE_BIT];
  wire ulaw_sel              = ctrl[pcmsig_pkg::CTRL_ULAW_BIT];
  wire linear_mode           = ctrl[pcmsig_pkg::CTRL_LINEAR_BIT];
  wire chan_active           = ctrl[pcmsig_pkg::CTRL_ACTIVE_BIT];

  assign bus_done = (avs_read | avs_write) & ~avs_waitrequest;
  assign sel_ctrl = avs_write & bus_done & (avs_address == pcmsig_pkg::OFF_CTRL);
  assign sel_slot = avs_write & bus_done & (avs_address == pcmsig_pkg::OFF_SLOT);
  assign sel_tx   = avs_write & bus_done & (avs_address == pcmsig_pkg::OFF_TX_DATA);

  // one wait cycle per access; request completes on the second edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // control writes honour byte lanes; law select steers the expander
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl       <= pcmsig_pkg::CTRL_RESET;
      tx_slot    <= '0;
      rx_slot    <= '0;
      clock_slot <= '0;
      tx_data    <= 16'h0000;
      irq_mask   <= pcmsig_pkg::MASK_RESET;
    end else begin
      if (sel_ctrl && avs_byteenable[0]) begin
        ctrl <= avs_writedata[pcmsig_pkg::CTRL_W-1:0];
      end
      if (sel_slot && avs_byteenable[0]) begin
        tx_slot <= avs_writedata[pcmsig_pkg::SLOT_TX_LSB +: pcmsig_pkg::SLOT_W];
      end
      if (sel_slot && avs_byteenable[1]) begin
        clock_slot <= avs_writedata[pcmsig_pkg::SLOT_CS_LSB +: pcmsig_pkg::CSLOT_W];
      end
      if (sel_slot && avs_byteenable[2]) begin
        rx_slot <= avs_writedata[pcmsig_pkg::SLOT_RX_LSB +: pcmsig_pkg::SLOT_W];
      end
      if (sel_tx && avs_byteenable[0]) begin
        tx_data[7:0] <= avs_writedata[7:0];
      end
      if (sel_tx && avs_byteenable[1]) begin
        tx_data[15:8] <= avs_writedata[15:8];
      end
      if (avs_write && bus_done && avs_address == pcmsig_pkg::OFF_IRQ_MASK
          && avs_byteenable[0]) begin
        irq_mask <= avs_writedata[pcmsig_pkg::IRQ_W-1:0];
      end
    end
  end

  // -----------------------------------------------------------------
  // hook debounce
  // -----------------------------------------------------------------
  logic            hook_deb;
  logic [DB_W-1:0] db_cnt;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hook_deb <= 1'b0;
      db_cnt   <= '0;
    end else if (hook_s == hook_deb) begin
      db_cnt <= '0;
    end else if (db_cnt == DB_W'(HOOK_DEBOUNCE_CYCLES - 1)) begin
      hook_deb <= hook_s;
      db_cnt   <= '0;
    end else begin
      db_cnt <= db_cnt + DB_W'(1);
    end
  end

  // reserved bits stay zero
  logic [7:0] sig_byte;
  always_comb begin
    sig_byte = 8'h00;
    sig_byte[pcmsig_pkg::SIGB_HOOK_BIT]  = hook_deb;
    sig_byte[pcmsig_pkg::SIGB_LINE_BIT]  = ctrl[pcmsig_pkg::CTRL_MUXSEL_BIT] ? mux_s : line2_s;
    sig_byte[pcmsig_pkg::SIGB_CLOCK_FAIL_FLAG_BIT] = clock_fail_flag_s;
  end

  // -----------------------------------------------------------------
  // bit clock edges, frame sync and bit counter
  // -----------------------------------------------------------------
  logic          pclk_d, pclk_rise, pclk_fall;
  logic          fs_prev;
  logic [1:0]    fs_run;
  logic          prev_two, robbed_frame, frame_seen;
  logic [BW-1:0] bit_cnt, next_bit_cnt;
  logic          pulse_end, frame_start;

  assign pclk_rise   = pclk_s & ~pclk_d;
  assign pclk_fall   = ~pclk_s & pclk_d;
  assign frame_start = pclk_fall & fs_s & ~fs_prev;
  assign pulse_end   = pclk_fall & ~fs_s & (fs_run != 2'h0);
  assign next_bit_cnt = (bit_cnt == {BW{1'b1}} - BW'(1)) ? bit_cnt : bit_cnt + BW'(1);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pclk_d <= 1'b0;
    end else begin
      pclk_d <= pclk_s;
    end
  end

  // frame sync sampled on falling bit clock; pulse length classified at its end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fs_prev      <= 1'b0;
      fs_run       <= 2'h0;
      prev_two     <= 1'b0;
      robbed_frame <= 1'b0;
    end else if (pclk_fall) begin
      fs_prev <= fs_s;
      if (fs_s) begin
        fs_run <= (fs_run == 2'h3) ? fs_run : fs_run + 2'h1;
      end else begin
        fs_run <= 2'h0;
      end
      if (pulse_end) begin
        prev_two     <= (fs_run == pcmsig_pkg::ROBBED_PULSE_LEN);
        robbed_frame <= robbed_bit_enable & ulaw_sel & ~prev_two
                        & (fs_run == pcmsig_pkg::ROBBED_PULSE_LEN);
      end
    end
  end

  // slot 0 bit 0 begins at the first rising edge after the sync sample
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt    <= {BW{1'b1}};
      frame_seen <= 1'b0;
    end else if (frame_start) begin
      bit_cnt    <= {BW{1'b1}};
      frame_seen <= 1'b1;
    end else if (pclk_rise && bit_cnt == {BW{1'b1}}) begin
      bit_cnt <= '0;
    end else if (pclk_rise) begin
      bit_cnt <= next_bit_cnt;
    end
  end

  // -----------------------------------------------------------------
  // transmit: sample slot, then signaling slot at same offset
  // -----------------------------------------------------------------
  logic [BW-1:0] tx_start, tx_idx, cnt_after;
  logic          tx_expect_bit;
  assign tx_start  = BW'({tx_slot, 3'h0}) + BW'(clock_slot);
  assign cnt_after = (bit_cnt == {BW{1'b1}}) ? '0 : next_bit_cnt;
  assign tx_idx    = cnt_after - tx_start;
  assign tx_expect_bit = tx_data[3'h7 - tx_idx[2:0]];

  // robbed-bit state never enters this path: full bytes always go out
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pcm_tx_out <= 1'b0;
      pcm_tx_oe  <= 1'b0;
    end else if (pclk_rise) begin
      pcm_tx_out <= 1'b0;
      pcm_tx_oe  <= 1'b0;
      if (frame_seen && linear_mode && chan_active && tx_idx < BW'(16)) begin
        pcm_tx_out <= tx_data[4'hf - tx_idx[3:0]];
        pcm_tx_oe  <= 1'b1;
      end else if (frame_seen && !linear_mode && chan_active && tx_idx < BW'(8)) begin
        pcm_tx_out <= tx_expect_bit;
        pcm_tx_oe  <= 1'b1;
      end else if (frame_seen && !linear_mode && signaling_slot_enable
                   && tx_idx >= BW'(8) && tx_idx < BW'(16)) begin
        pcm_tx_out <= sig_byte[3'h7 - tx_idx[2:0]];
        pcm_tx_oe  <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // receive: shift on falling edges, expand at end of slot
  // -----------------------------------------------------------------
  pcmsig_exp_if ex ();
  pcmsig_expander u_expander (.x(ex.expander));

  logic [BW-1:0] rx_start, rx_idx;
  logic [15:0]   rx_shift;
  logic          rx_capture;
  assign rx_start   = BW'({rx_slot, 3'h0}) + BW'(clock_slot);
  assign rx_idx     = bit_cnt - rx_start;
  assign rx_capture = pclk_fall & frame_seen & ~frame_start
                      & (rx_idx == (linear_mode ? BW'(15) : BW'(7)));
  assign ex.code     = {rx_shift[6:0], rxd_s};
  assign ex.ulaw     = ulaw_sel;
  assign ex.half_lsb = robbed_frame & robbed_bit_enable & ulaw_sel;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift  <= 16'h0000;
      rx_data   <= 16'h0000;
      rx_linear <= 16'h0000;
    end else begin
      if (pclk_fall) begin
        rx_shift <= {rx_shift[14:0], rxd_s};
      end
      if (rx_capture) begin
        rx_data   <= {rx_shift[14:0], rxd_s};
        rx_linear <= linear_mode ? {rx_shift[14:0], rxd_s} : ex.linear;
      end
    end
  end

  // -----------------------------------------------------------------
  // interrupts and read path
  // -----------------------------------------------------------------
  logic clr_status;
  assign irq_set    = {pulse_end & robbed_bit_enable & ulaw_sel & ~prev_two
                       & (fs_run == pcmsig_pkg::ROBBED_PULSE_LEN), rx_capture, frame_start};
  assign clr_status = avs_read & bus_done & (avs_address == pcmsig_pkg::OFF_IRQ_STATUS);

  // set beats the read-clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (clr_status ? '0 : irq_status) | irq_set;
      irq        <= |(((clr_status ? '0 : irq_status) | irq_set) & irq_mask);
    end
  end

  logic [31:0] next_readdata;
  always_comb begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      pcmsig_pkg::OFF_CTRL:       next_readdata = 32'(ctrl);
      pcmsig_pkg::OFF_SLOT:       next_readdata = {9'h000, rx_slot, 5'h00, clock_slot,
                                                   1'b0, tx_slot};
      pcmsig_pkg::OFF_TX_DATA:    next_readdata = {16'h0000, tx_data};
      pcmsig_pkg::OFF_RX_DATA:    next_readdata = {16'h0000, rx_data};
      pcmsig_pkg::OFF_RX_LINEAR:  next_readdata = {16'h0000, rx_linear};
      pcmsig_pkg::OFF_LINE_STAT:  next_readdata = {22'h000000, prev_two, robbed_frame, sig_byte};
      pcmsig_pkg::OFF_IRQ_STATUS: next_readdata = 32'(irq_status);
      pcmsig_pkg::OFF_IRQ_MASK:   next_readdata = 32'(irq_mask);
      default:                    next_readdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= next_readdata;
    end
  end

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  property p_sig_follows;
    @(posedge core_clk) disable iff (!rst_n)
    pclk_rise && frame_seen && !linear_mode && signaling_slot_enable && tx_idx == BW'(8)
    |=> pcm_tx_oe && pcm_tx_out == $past(sig_byte[7]);
  endproperty
  a_sig_follows: assert property (p_sig_follows) else $error("signaling bit 7 late");

  property p_sig_inactive;
    @(posedge core_clk) disable iff (!rst_n)
    pclk_rise && frame_seen && !linear_mode && signaling_slot_enable && !chan_active
    && tx_idx >= BW'(8) && tx_idx < BW'(16) |=> pcm_tx_oe;
  endproperty
  a_sig_inactive: assert property (p_sig_inactive) else $error("signaling slot idle");

  property p_sig_layout;
    @(posedge core_clk) disable iff (!rst_n)
    sig_byte[7] == hook_deb && sig_byte[2] == clock_fail_flag_s && sig_byte[5:3] == 3'h0
    && sig_byte[1:0] == 2'h0;
  endproperty
  a_sig_layout: assert property (p_sig_layout) else $error("signaling byte layout");

  property p_tx_byte;
    @(posedge core_clk) disable iff (!rst_n)
    pclk_rise && frame_seen && !linear_mode && chan_active && tx_idx < BW'(8)
    |=> pcm_tx_oe && pcm_tx_out == $past(tx_expect_bit);
  endproperty
  a_tx_byte: assert property (p_tx_byte) else $error("tx byte altered");

  property p_half_only_ulaw;
    @(posedge core_clk) disable iff (!rst_n)
    ex.half_lsb |-> ex.ulaw && robbed_bit_enable && robbed_frame;
  endproperty
  a_half_only_ulaw: assert property (p_half_only_ulaw) else $error("half lsb off mu");

  property p_robbed_set;
    @(posedge core_clk) disable iff (!rst_n)
    pulse_end && fs_run == 2'h2 && !prev_two && robbed_bit_enable && ulaw_sel
    |=> robbed_frame && prev_two;
  endproperty
  a_robbed_set: assert property (p_robbed_set) else $error("robbed frame missed");

  property p_long_pulse;
    @(posedge core_clk) disable iff (!rst_n)
    pulse_end && fs_run != 2'h2 |=> !robbed_frame && !prev_two;
  endproperty
  a_long_pulse: assert property (p_long_pulse) else $error("bad pulse classified");

  property p_slot_zero;
    @(posedge core_clk) disable iff (!rst_n)
    frame_start |=> bit_cnt == {BW{1'b1}} && frame_seen;
  endproperty
  a_slot_zero: assert property (p_slot_zero) else $error("frame start not slot 0");

  c_robbed: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(robbed_frame));
  c_sig_tx: cover property (@(posedge core_clk) disable iff (!rst_n)
    pclk_rise && signaling_slot_enable && tx_idx == BW'(15));
  c_rx_cap: cover property (@(posedge core_clk) disable iff (!rst_n)
    rx_capture && ex.half_lsb);
  c_irq:    cover property (@(posedge core_clk) disable iff (!rst_n) $rose(irq));

endmodule : pcmsig_framer

// file: pcmsig_highway_model.sv
// ---------------------------------------------
// backplane side: bit clock, sync, rx bits
// ---------------------------------------------
module pcmsig_highway_model (
  output logic      pcm_clk,
  output logic      frame_sync,
  output logic      pcm_rx_data,
  input  wire logic pcm_tx_out,
  input  wire logic pcm_tx_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // free-running 64 ns bit clock
  initial begin
    pcm_clk = 1'b0;
    frame_sync = 1'b0;
    pcm_rx_data = 1'b0;
    forever #32 pcm_clk = ~pcm_clk;
  end
  // one 32-bit frame; tx taken at the next rise, a full period after launch
  task automatic frame(input int fs_len, input logic [7:0] rxb, output logic [15:0] txw);
    @(posedge pcm_clk);
    frame_sync <= 1'b1;
    for (int n = 0; n <= 32; n++) begin
      @(posedge pcm_clk);
      // an undriven highway floats to its pull-up level
      if (n >= 1 && n <= 16) txw[16-n] = pcm_tx_oe ? pcm_tx_out : 1'b1;
      if (n == fs_len - 1) frame_sync <= 1'b0;
      // rx slot 1 only; elsewhere the line keeps toggling
      pcm_rx_data <= (n >= 8 && n < 16) ? rxb[15-n] : ~pcm_rx_data;
    end
  endtask : frame
endmodule : pcmsig_highway_model

// file: pcmsig_pkg.sv
// Operation
// - With signaling enabled each companded channel uses two back-to-back slots, sample then signaling byte.
// - The signaling byte holds debounced hook at bit 7, line two or muxed hook at bit 6, clock fail at bit 2.
// - Signaling bit 7 is shifted on the bit period right after sample bit 0, with no gap.
// - The signaling slot is driven even while the channel is inactive.
// - Robbed-bit mode is switched on by the robbed-bit enable bit.
// - Robbed-bit handling applies only under mu-law and only on the receive path.
// - Transmit bytes are always complete and never touched by robbed-bit mode.
// - In a robbed-bit frame the received LSB is dropped and half its weight is fed to the expander.
// - A robbed-bit frame needs enable, mu-law, a two-cycle sync pulse now and not the time before.
// - Sync is sampled on falling bit clock edges; high, high, then low marks a two-cycle pulse.
// - Half-weight substitution hits only the channel's own receive slot in a robbed-bit frame.
// - The companding law is chosen by the A-law/mu-law select bit.
// - The sync pulse marks slot 0 and all slots are counted from it.
package pcmsig_pkg;

  // -----------------------------------------------------------------
  // register map, byte addresses
  // -----------------------------------------------------------------
  localparam logic [4:0] OFF_CTRL       = 5'h00;
  localparam logic [4:0] OFF_SLOT       = 5'h04;
  localparam logic [4:0] OFF_TX_DATA    = 5'h08;
  localparam logic [4:0] OFF_RX_DATA    = 5'h0c;
  localparam logic [4:0] OFF_RX_LINEAR  = 5'h10;
  localparam logic [4:0] OFF_LINE_STAT  = 5'h14;
  localparam logic [4:0] OFF_IRQ_STATUS = 5'h18;
  localparam logic [4:0] OFF_IRQ_MASK   = 5'h1c;

  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int CTRL_SIG_EN_BIT = 0;
  localparam int CTRL_RBE_BIT    = 1;
  localparam int CTRL_ULAW_BIT   = 2;
  localparam int CTRL_LINEAR_BIT = 3;
  localparam int CTRL_ACTIVE_BIT = 4;
  localparam int CTRL_MUXSEL_BIT = 5;
  localparam int CTRL_W          = 6;
  localparam int SLOT_TX_LSB     = 0;
  localparam int SLOT_CS_LSB     = 8;
  localparam int SLOT_RX_LSB     = 16;
  localparam int SIGB_HOOK_BIT   = 7;
  localparam int SIGB_LINE_BIT   = 6;
  localparam int SIGB_CLOCK_FAIL_FLAG_BIT  = 2;
  localparam int LSTAT_ROB_BIT   = 8;
  localparam int LSTAT_PREV2_BIT = 9;
  localparam int IRQ_FRAME_BIT   = 0;
  localparam int IRQ_RX_BIT      = 1;
  localparam int IRQ_ROBBED_BIT  = 2;
  localparam int IRQ_W           = 3;

  // -----------------------------------------------------------------
  // reset values and widths
  // -----------------------------------------------------------------
  localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;
  localparam logic [IRQ_W-1:0]  MASK_RESET = 3'h0;
  localparam int SLOT_W     = 7;
  localparam int CSLOT_W    = 3;
  localparam int BIT_CNT_W  = 11;
  localparam int SYNC_N     = 7;

  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int CLK_PERIOD_NS    = 8;
  localparam int HOOK_DEBOUNCE_NS = 1000000;
  localparam int HOOK_DEBOUNCE_CYC = (HOOK_DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] ROBBED_PULSE_LEN = 2'h2;

endpackage : pcmsig_pkg

// file: test_pcm_signaling_robbed_bit.sv
module test_pcm_signaling_robbed_bit;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [5:0] ctrl; int fs; logic [7:0] rxb; logic rob; logic [7:0] sig;} pcmsig_row_t;
  logic        core_clk, rst_n, avs_read, avs_write, avs_waitrequest, irq;
  logic        pcm_clk, frame_sync, pcm_rx_data, pcm_tx_out, pcm_tx_oe;
  logic [4:0]  avs_address;
  logic [3:0]  avs_byteenable;
  logic [7:0]  hi_b;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [15:0] txw;
  int          mismatches = 0;
  int          num_checks = 0;
  // order matters: each row sees the previous row's pulse; in the linear row (1d)
  // the last field is the low byte of the sent word, not a signaling byte
  pcmsig_row_t rows[10] = '{'{6'h17, 2, 8'h35, 1, 8'hc4}, '{6'h17, 2, 8'h35, 0, 8'hc4},
    '{6'h17, 1, 8'h7e, 0, 8'hc4}, '{6'h07, 2, 8'h7e, 1, 8'hc4}, '{6'h17, 3, 8'h35, 0, 8'hc4},
    '{6'h14, 2, 8'h35, 0, 8'hff}, '{6'h13, 1, 8'h35, 0, 8'hc4}, '{6'h13, 2, 8'h35, 0, 8'hc4},
    '{6'h1d, 1, 8'h35, 0, 8'ha5}, '{6'h37, 2, 8'h7e, 1, 8'h84}};
  pcmsig_framer #(.HOOK_DEBOUNCE_CYCLES(4)) uut (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .pcm_clk(pcm_clk), .frame_sync(frame_sync),
    .pcm_rx_data(pcm_rx_data), .pcm_tx_out(pcm_tx_out), .pcm_tx_oe(pcm_tx_oe),
    .hook_detect_input(1'b1), .second_line_input(1'b1), .muxed_hook_input(1'b0),
    .clock_fail_flag(1'b1));
  pcmsig_highway_model hw (.pcm_clk(pcm_clk), .frame_sync(frame_sync),
    .pcm_rx_data(pcm_rx_data), .pcm_tx_out(pcm_tx_out), .pcm_tx_oe(pcm_tx_oe));
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // mu-law expansion, mantissa lsb optionally replaced by half weight
  function automatic logic [15:0] mu_exp(input logic [7:0] c, input logic half);
    logic [7:0] x;
    int         m;
    x = ~c;
    m = ((half ? ({28'h0, x[3:1], 1'b0} * 8 + 4) : {28'h0, x[3:0]} * 8) + 132) << x[6:4];
    m = m - 132;
    return x[7] ? 16'(-m) : 16'(m);
  endfunction : mu_exp
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  // ---------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // frames take about 2.2 us each; ample margin
  initial begin
    #200000;
    mismatches++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    repeat (20) @(posedge core_clk);
    chk("reset_oe", 0, {avs_readdata[0], irq, pcm_tx_oe, !avs_waitrequest});
    rst_n <= 1'b1;
    bus(0, pcmsig_pkg::OFF_CTRL, 0, q);
    chk("ctrl_reset", 0, q);
    bus(0, pcmsig_pkg::OFF_IRQ_MASK, 0, q);
    chk("mask_reset", 0, q);
    // a write with lane 0 disabled must leave the control byte alone
    avs_byteenable <= 4'he;
    bus(1, pcmsig_pkg::OFF_CTRL, 32'h0000003f, q);
    avs_byteenable <= 4'hf;
    bus(0, pcmsig_pkg::OFF_CTRL, 0, q);
    chk("ctrl_lane0", 0, q);
    bus(1, pcmsig_pkg::OFF_TX_DATA, 32'h000000a5, q);
    bus(1, pcmsig_pkg::OFF_SLOT, 32'h00010000, q);
    foreach (rows[i]) begin
      bus(1, pcmsig_pkg::OFF_CTRL, 32'(rows[i].ctrl), q);
      hw.frame(rows[i].fs, rows[i].rxb, txw);
      // inactive: sample slot floats; linear: high byte of the data word
      hi_b = rows[i].ctrl[4] ? (rows[i].ctrl[3] ? 8'h00 : 8'ha5) : 8'hff;
      chk("tx_word", {16'h0, hi_b, rows[i].sig}, 32'(txw));
      bus(0, pcmsig_pkg::OFF_LINE_STAT, 0, q);
      chk("robbed_frame", 32'(rows[i].rob), 32'(q[8]));
      if (rows[i].ctrl[2] & rows[i].ctrl[4] & !rows[i].ctrl[3]) begin
        bus(0, pcmsig_pkg::OFF_RX_LINEAR, 0, q);
        chk("rx_linear", 32'(mu_exp(rows[i].rxb, rows[i].rob)), 32'(q[15:0]));
      end
    end
    // robbed-frame interrupt: masked source, raise, read-clear
    bus(1, pcmsig_pkg::OFF_IRQ_MASK, 32'h4, q);
    bus(0, pcmsig_pkg::OFF_IRQ_STATUS, 0, q);
    hw.frame(1, 8'h35, txw);
    chk("irq_idle", 0, irq);
    hw.frame(2, 8'h35, txw);
    chk("irq_robbed", 1, irq);
    bus(0, pcmsig_pkg::OFF_IRQ_STATUS, 0, q);
    chk("irq_status", 32'h4, q & 32'h4);
    repeat (3) @(posedge core_clk);
    chk("irq_cleared", 0, irq);
    // mid-run reset: the two-cycle pulse just seen must be forgotten
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("reset_mid", 0, {avs_readdata[28:0], irq, pcm_tx_oe, !avs_waitrequest});
    rst_n <= 1'b1;
    bus(1, pcmsig_pkg::OFF_CTRL, 32'h00000017, q);
    hw.frame(2, 8'h35, txw);
    chk("tx_after_reset", 32'h000000c4, 32'(txw));
    bus(0, pcmsig_pkg::OFF_LINE_STAT, 0, q);
    chk("robbed_after_reset", 1, 32'(q[8]));
    final_report();
  end
endmodule : test_pcm_signaling_robbed_bit
